// file: reis_top.sv
// reis_top: rising-event input qualifier for the output generator
// assumes: on-chip sources are synchronous, the mapped pin is not
// Summary of operation
// - bit 7 of enable and mode reads zero
// - enable bit 6 admits pwm unit three
// - enable bit 5 admits capture compare two
// - enable bit 4 admits capture compare one
// - enable bit 3 admits logic cell one
// - enable bit 2 admits comparator two
// - enable bit 1 admits comparator one
// - enable bit 0 admits the mapped pin
// - disabled source never affects rising events
// - mode one: edge fires after phase delay
// - mode zero: high level fires on the next clock, with no phase delay
// - mode ignored while source disabled
// - mode bit n governs source n
`timescale 1ns/10ps
`default_nettype none
module reis_top #(
  parameter int unsigned PHASE_W = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // register port
  input wire logic [reis_pkg::ADDR_W-1:0] i_addr,
  input wire logic [reis_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [reis_pkg::DATA_W-1:0] o_rdata,
  // trigger sources
  input wire logic i_mapped_pin,
  input wire logic i_comparator_one,
  input wire logic i_comparator_two,
  input wire logic i_logic_cell_one,
  input wire logic i_capture_compare_unit_one,
  input wire logic i_capture_compare_unit_two,
  input wire logic i_pwm_unit_three,
  // to waveform core
  output logic o_rise_event
);
  logic [6:0] rise_en_r;
  logic [6:0] rise_mode_r;
  logic [PHASE_W-1:0] phase_r;
  logic [6:0] prev_r;
  logic [reis_pkg::DATA_W-1:0] rdata_r;
  logic [reis_pkg::DATA_W-1:0] rdata_nxt;
  logic rise_r;
  logic rise_nxt;
  logic pin_level;
  logic [6:0] src;
  logic [6:0] edge_hit;
  logic [6:0] level_hit;
  logic any_edge;
  logic any_level;
  logic ph_done;
  logic ph_busy;
  logic wr_en;
  logic wr_mode;
  logic wr_phase;
  logic rise_en_mapped_pin;
  logic rise_en_comparator_one;
  logic rise_en_comparator_two;
  logic rise_en_logic_cell_one;
  logic rise_en_capcomp_one;
  logic rise_en_capcomp_two;
  logic rise_en_pwm_three;

  // only the pin is asynchronous; internal sources share the clock
  reis_sync u_pin_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async(i_mapped_pin),
    .o_level(pin_level)
  );

  assign rise_en_mapped_pin = rise_en_r[reis_pkg::BIT_MAPPED_PIN];
  assign rise_en_comparator_one = rise_en_r[reis_pkg::BIT_COMPARATOR_ONE];
  assign rise_en_comparator_two = rise_en_r[reis_pkg::BIT_COMPARATOR_TWO];
  assign rise_en_logic_cell_one = rise_en_r[reis_pkg::BIT_LOGIC_CELL_ONE];
  assign rise_en_capcomp_one = rise_en_r[reis_pkg::BIT_CAPCOMP_ONE];
  assign rise_en_capcomp_two = rise_en_r[reis_pkg::BIT_CAPCOMP_TWO];
  assign rise_en_pwm_three = rise_en_r[reis_pkg::BIT_PWM_THREE];

  assign src[reis_pkg::BIT_MAPPED_PIN] = pin_level & rise_en_mapped_pin;
  assign src[reis_pkg::BIT_COMPARATOR_ONE] = i_comparator_one & rise_en_comparator_one;
  assign src[reis_pkg::BIT_COMPARATOR_TWO] = i_comparator_two & rise_en_comparator_two;
  assign src[reis_pkg::BIT_LOGIC_CELL_ONE] = i_logic_cell_one & rise_en_logic_cell_one;
  assign src[reis_pkg::BIT_CAPCOMP_ONE] = i_capture_compare_unit_one & rise_en_capcomp_one;
  assign src[reis_pkg::BIT_CAPCOMP_TWO] = i_capture_compare_unit_two & rise_en_capcomp_two;
  assign src[reis_pkg::BIT_PWM_THREE] = i_pwm_unit_three & rise_en_pwm_three;

  // gated source also feeds the edge history, so enabling a high source counts as an edge
  genvar g;
  generate
    for (g = 0; g < reis_pkg::NUM_SRC; g++) begin : g_src
      assign edge_hit[g] = rise_en_r[g] & rise_mode_r[g] & src[g] & ~prev_r[g];
      assign level_hit[g] = rise_en_r[g] & ~rise_mode_r[g] & src[g];
    end
  endgenerate

  assign any_edge = |edge_hit;
  assign any_level = |level_hit;

  // delay restarts on each new edge; phase_r is software's to set first
  reis_phase #(.W(PHASE_W)) u_phase (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_start(any_edge),
    .i_delay(phase_r),
    .o_done(ph_done),
    .o_busy(ph_busy)
  );

  assign rise_nxt = any_level | ph_done;

  assign wr_en = i_wr && (i_addr == reis_pkg::OFF_RISE_EN);
  assign wr_mode = i_wr && (i_addr == reis_pkg::OFF_RISE_MODE);
  assign wr_phase = i_wr && (i_addr == reis_pkg::OFF_PHASE);

  always_comb begin
    rdata_nxt = '0;
    if (i_rd) begin
      unique case (i_addr)
        reis_pkg::OFF_RISE_EN: rdata_nxt = {1'b0, rise_en_r};
        reis_pkg::OFF_RISE_MODE: rdata_nxt = {1'b0, rise_mode_r};
        reis_pkg::OFF_PHASE: rdata_nxt = reis_pkg::DATA_W'(phase_r);
        reis_pkg::OFF_STATUS: begin
          rdata_nxt[reis_pkg::STAT_BUSY] = ph_busy;
          rdata_nxt[reis_pkg::STAT_PEND] = rise_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rise_en_r <= reis_pkg::RST_RISE_EN[6:0];
      rise_mode_r <= reis_pkg::RST_RISE_MODE[6:0];
      phase_r <= PHASE_W'(reis_pkg::RST_PHASE);
      prev_r <= '0;
      rdata_r <= '0;
      rise_r <= 1'b0;
    end else begin
      if (wr_en) begin
        rise_en_r <= i_wdata[6:0];
      end
      if (wr_mode) begin
        rise_mode_r <= i_wdata[6:0];
      end
      if (wr_phase) begin
        phase_r <= i_wdata[PHASE_W-1:0];
      end
      prev_r <= src;
      rdata_r <= rdata_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rise_event = rise_r;
endmodule
`default_nettype wire

// file: reis_pkg.sv
// reis_pkg: constants for the rising-event input select block
// assumes: a plain register port with 8-bit data and one-cycle read latency
package reis_pkg;
  localparam int unsigned NUM_SRC = 7;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFF_RISE_EN = 4'h0;
  localparam logic [3:0] OFF_RISE_MODE = 4'h1;
  localparam logic [3:0] OFF_PHASE = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h3;
  // reset values
  localparam logic [7:0] RST_RISE_EN = 8'h00;
  localparam logic [7:0] RST_RISE_MODE = 8'h00;
  localparam logic [7:0] RST_PHASE = 8'h00;
  // implemented bits of enable and mode
  localparam logic [7:0] SRC_MASK = 8'h7F;
  // source bit positions
  localparam int unsigned BIT_MAPPED_PIN = 0;
  localparam int unsigned BIT_COMPARATOR_ONE = 1;
  localparam int unsigned BIT_COMPARATOR_TWO = 2;
  localparam int unsigned BIT_LOGIC_CELL_ONE = 3;
  localparam int unsigned BIT_CAPCOMP_ONE = 4;
  localparam int unsigned BIT_CAPCOMP_TWO = 5;
  localparam int unsigned BIT_PWM_THREE = 6;
  // status fields
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_PEND = 1;
  localparam logic [7:0] PHASE_ONE = 8'h01;
endpackage

// file: reis_sync.sv
// reis_sync: three-stage pin synchroniser with agreement filter
// assumes: input is asynchronous to i_clock
`timescale 1ns/10ps
`default_nettype none
module reis_sync (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // async pin and clean level
  input wire logic i_async,
  output logic o_level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic level_nxt;

  // first stage feeds only the second, to keep metastability contained
  assign level_nxt = (s2_r == s3_r) ? s3_r : level_r;
  assign o_level = level_r;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end
endmodule
`default_nettype wire

// file: reis_phase.sv
// reis_phase: phase-delay timer for edge-mode rising events
// assumes: start is a one-cycle pulse from the same clock
`timescale 1ns/10ps
`default_nettype none
module reis_phase #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // control
  input wire logic i_start,
  input wire logic [W-1:0] i_delay,
  // result
  output logic o_done,
  output logic o_busy
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic last;

  // zero delay fires on the cycle after the start
  assign last = busy_r && (cnt_r == '0);
  assign o_done = last;
  assign o_busy = busy_r;
  assign busy_nxt = i_start ? 1'b1 : (last ? 1'b0 : busy_r);
  assign cnt_nxt = i_start ? i_delay : (busy_r && !last ? cnt_r - 1'b1 : cnt_r);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end
endmodule
`default_nettype wire

// file: reis_src_model.sv
// reis_src_model: stands in for the on-chip trigger sources and the pin
// assumes: levels come from the bench just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module reis_src_model (
  // requested levels
  input wire logic [6:0] i_lvl,
  // source outputs, bit n feeds source n
  output logic [6:0] o_src
);
  // on-chip units follow the clock directly
  assign o_src[6:1] = i_lvl[6:1];
  // the pin lands off the edge, so the synchroniser sees a real async input
  assign #3 o_src[0] = i_lvl[0];
endmodule
`default_nettype wire

// file: reis_top_asserts.sv
// reis_top_asserts: port checker for reis_top
// assumes: bound to every reis_top, registers shadowed from writes
`timescale 1ns/10ps
`default_nettype none
module reis_top_asserts #(
  parameter int unsigned PHASE_W = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // sources and result
  input wire logic i_mapped_pin, i_comparator_one, i_comparator_two, i_logic_cell_one,
  input wire logic i_capture_compare_unit_one, i_capture_compare_unit_two, i_pwm_unit_three,
  input wire logic o_rise_event
);
  logic [7:0] en_r, mode_r, ph_r;
  logic [6:0] g_q;
  logic ever_r;
  // pin left out: its synchroniser delay is only approximate
  wire [6:0] src = {i_pwm_unit_three, i_capture_compare_unit_two, i_capture_compare_unit_one,
    i_logic_cell_one, i_comparator_two, i_comparator_one, 1'b0};
  wire [6:0] g = en_r[6:0] & mode_r[6:0] & src;
  wire lvl = |(en_r[6:0] & ~mode_r[6:0] & src);
  wire edg = |(g & ~g_q);
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      en_r <= 8'h00;
      mode_r <= 8'h00;
      ph_r <= 8'h00;
      g_q <= 7'h00;
      ever_r <= 1'b0;
    end else begin
      if (i_wr && i_addr == reis_pkg::OFF_RISE_EN) en_r <= i_wdata;
      if (i_wr && i_addr == reis_pkg::OFF_RISE_MODE) mode_r <= i_wdata;
      if (i_wr && i_addr == reis_pkg::OFF_PHASE) ph_r <= i_wdata;
      // history follows the enable gate only, as the design's edge history does
      g_q <= en_r[6:0] & src;
      ever_r <= ever_r | (|en_r);
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata not idle");
  chk_en_top: assert property ($past(i_rd) && $past(i_addr) == reis_pkg::OFF_RISE_EN
    |-> o_rdata == {1'b0, $past(en_r[6:0])}) else $error("enable readback wrong");
  chk_mode_top: assert property ($past(i_rd) && $past(i_addr) == reis_pkg::OFF_RISE_MODE
    |-> o_rdata == {1'b0, $past(mode_r[6:0])}) else $error("mode readback wrong");
  chk_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 4'h3 |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_never_enabled: assert property (!ever_r && en_r == 8'h00 |-> !o_rise_event)
    else $error("event with no source enabled");
  chk_level_fire: assert property (lvl |-> ##1 o_rise_event) else $error("level missed");
  chk_edge_pulse: assert property (o_rise_event && !$past(lvl) && !en_r[0] |=> !o_rise_event)
    else $error("edge pulse too long");
  chk_edge_delay: assert property ((edg && ph_r == 8'h00 && !en_r[0]) ##1 !edg |-> ##1 o_rise_event)
    else $error("edge event late");
  cover property (lvl ##1 o_rise_event);
  cover property (edg && ph_r != 8'h00);
  cover property ($past(i_rd) && $past(i_addr) > 4'h3);
endmodule
bind reis_top reis_top_asserts #(.PHASE_W(PHASE_W)) u_chk (.*);
`default_nettype wire

// file: tb_rising_event_input_select.sv
// tb_rising_event_input_select: self-checking bench for reis_top
// assumes: package, design, checker and source model compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_rising_event_input_select;
  logic i_clock = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, v;
  logic [6:0] lvl = 7'h00, src;
  logic o_rise_event, ev_q = 1'b0, rd_q = 1'b0, quiet = 1'b0;
  logic [7:0] rd_exp[$];
  int ev_exp[$];
  int cyc = 0, n_mismatch = 0, total_checks = 0;
  always #12.5 i_clock = ~i_clock;
  reis_src_model model (.i_lvl(lvl), .o_src(src));
  reis_top dut (.i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mapped_pin(src[0]),
    .i_comparator_one(src[1]), .i_comparator_two(src[2]), .i_logic_cell_one(src[3]),
    .i_capture_compare_unit_one(src[4]), .i_capture_compare_unit_two(src[5]),
    .i_pwm_unit_three(src[6]), .o_rise_event(o_rise_event));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    rd_exp.push_back(e);
    @(posedge i_clock);
    i_rd <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // any unannounced event counts against the run unless quiet is set
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (rd_q) check(o_rdata, rd_exp.pop_front());
    if (o_rise_event && !ev_q && !quiet) check(8'(cyc), 8'(ev_exp.size() > 0 ? ev_exp.pop_front() : cyc + 1));
    rd_q = i_rd;
    ev_q = o_rise_event;
  end
  always @(posedge i_clock) if (cyc == 6000) begin
    n_mismatch++;
    complete_run();
  end
  initial begin
    v = 8'($urandom(32'h1095a62b));
    repeat (3) @(posedge i_clock);
    i_srst <= 1'b0;
    rd(reis_pkg::OFF_RISE_EN, 8'h00);
    rd(reis_pkg::OFF_RISE_MODE, 8'h00);
    rd(4'hF, 8'h00);
    for (int i = 0; i < 20; i++) begin
      wr(reis_pkg::OFF_RISE_MODE, 8'($urandom));
      lvl <= 7'($urandom);
    end
    lvl <= 7'h00;
    repeat (6) @(posedge i_clock);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(reis_pkg::OFF_RISE_EN, v);
      rd(reis_pkg::OFF_RISE_EN, v & 8'h7F);
      wr(reis_pkg::OFF_RISE_MODE, ~v);
      rd(reis_pkg::OFF_RISE_MODE, ~v & 8'h7F);
    end
    for (int b = 1; b < 7; b++) begin
      wr(reis_pkg::OFF_RISE_MODE, 8'h00);
      wr(reis_pkg::OFF_RISE_EN, 8'(1 << b));
      @(posedge i_clock);
      ev_exp.push_back(cyc + 2);
      // a disabled neighbour is high too and must not matter
      lvl <= 7'(1 << b) | 7'(1 << (b % 6 + 1));
      repeat (5) @(posedge i_clock);
      lvl <= 7'h00;
      repeat (4) @(posedge i_clock);
      wr(reis_pkg::OFF_PHASE, 8'(b - 1));
      rd(reis_pkg::OFF_PHASE, 8'(b - 1));
      wr(reis_pkg::OFF_RISE_MODE, 8'(1 << b));
      @(posedge i_clock);
      ev_exp.push_back(cyc + b + 2);
      lvl <= 7'(1 << b);
      repeat (b + 6) @(posedge i_clock);
      lvl <= 7'h00;
      repeat (3) @(posedge i_clock);
    end
    wr(reis_pkg::OFF_RISE_MODE, 8'h00);
    wr(reis_pkg::OFF_RISE_EN, 8'h7E);
    @(posedge i_clock);
    ev_exp.push_back(cyc + 2);
    lvl <= 7'h48;
    repeat (5) @(posedge i_clock);
    lvl <= 7'h08;
    repeat (4) @(posedge i_clock);
    lvl <= 7'h00;
    wr(reis_pkg::OFF_RISE_EN, 8'h01);
    repeat (4) @(posedge i_clock);
    quiet <= 1'b1;
    lvl <= 7'h01;
    for (int i = 0; i < 10 && o_rise_event !== 1'b1; i++) @(posedge i_clock);
    check({7'h00, o_rise_event}, 8'h01);
    check(8'(ev_exp.size()), 8'h00);
    // pin still high: timer idle, event level pending
    rd(reis_pkg::OFF_STATUS, 8'h02);
    repeat (2) @(posedge i_clock);
    complete_run();
  end
endmodule
`default_nettype wire
